// *** rtl/plsc_regs.vh ***
// Constants for the LED, strap and reset control block.
`ifndef PLSC_REGS_VH
`define PLSC_REGS_VH
// Register addresses.
`define PLSC_ADDR_BASIC 4'h0
`define PLSC_ADDR_CODING 4'h1
`define PLSC_ADDR_STRAP 4'h2
`define PLSC_ADDR_STATUS 4'h3
`define PLSC_ADDR_LINK 4'h4
// Basic control fields.
`define PLSC_BC_LOOPBACK 14
`define PLSC_BC_ANEG 12
`define PLSC_BC_PDOWN 11
`define PLSC_BC_DUPLEX 8
// Coding control fields.
`define PLSC_CC_MLT3_BYPASS 1
// Strap status fields.
`define PLSC_SS_SPEED10 7
`define PLSC_SS_ACT 6
`define PLSC_SS_LINK 5
`define PLSC_SS_DUPCOL 4
`define PLSC_SS_SPEED100 3
// Link status bits written by software: speed10, speed100, link_good, activity, collision.
`define PLSC_LS_SPEED10 0
`define PLSC_LS_SPEED100 1
`define PLSC_LS_LINK 2
`define PLSC_LS_ACT 3
`define PLSC_LS_COL 4
// Status register fields.
`define PLSC_ST_RIP 0
`define PLSC_ST_PDOWN 1
// Timing: reference clock 100 MHz, reset hold 1 ms.
`define PLSC_CLK_HZ 100000000
`define PLSC_RESET_MS 1
`define PLSC_RESET_CYC ((`PLSC_CLK_HZ / 1000) * `PLSC_RESET_MS + 1)
`define PLSC_BLINK10_HZ 10
`define PLSC_BLINK20_HZ 20
`define PLSC_HALF10_CYC (`PLSC_CLK_HZ / (2 * `PLSC_BLINK10_HZ))
`define PLSC_HALF20_CYC (`PLSC_CLK_HZ / (2 * `PLSC_BLINK20_HZ))
`define PLSC_CNT_W 24
`define PLSC_RESET_BASIC 16'h1000
`define PLSC_RESET_CODING 16'h0000
`endif

// *** rtl/plsc_top.v ***
// LED driver, strap latch, configuration pins and reset sequencing of the transceiver.
`timescale 1ns/100ps
`include "plsc_regs.vh"
// Operation
// - 10 Mb/s LED steady on at 10 Mb/s
// - Strap speed10 pin into strap bit 7
// - Activity LED blinks 10 Hz when active
// - Strap activity pin into strap bit 6
// - Link LED on when good, blinks on activity
// - Strap link pin into strap bit 5
// - Duplex LED steady on in full duplex
// - Half duplex collision blinks LED at 20 Hz
// - Strap duplex pin into strap bit 4
// - 100 Mb/s LED steady on at 100
// - Strap speed100 pin into strap bit 3
// - Autoneg on: config inputs select advertisement
// - Autoneg off: config zero sets MLT-3 bypass
// - Autoneg on: config one joins advertisement selection
// - Autoneg off: config one sets loopback bit
// - Power-up reset lasts more than 1 ms
// - Reset-in-progress low until reset completes
// - Power down is pin OR control bit
// - Power down tri-states transmit and LEDs
module plsc_top
#(
  parameter RESET_CYCLES = `PLSC_RESET_CYC
)
(
  input wire clock,
  input wire reset,
  input wire reset_n_pin,
  input wire power_down_pin,
  input wire autoneg_strap_pin,
  input wire config_input_zero,
  input wire config_input_one,
  input wire full_duplex_pin,
  input wire [4:0] led_in,
  output reg [4:0] led_out,
  output reg [4:0] led_oe,
  output reg reset_done,
  output reg tx_line_oe,
  output reg mii_isolate,
  output reg [1:0] advert_mode,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata
);

  // LED index: 4 speed10, 3 activity, 2 link, 1 duplex/collision, 0 speed100.
  localparam ST_RESET = 2'b00;
  localparam ST_RUN = 2'b01;

  reg [1:0] state_r;
  reg [31:0] rst_cnt_r;
  reg [15:0] basic_r;
  reg [15:0] coding_r;
  reg [15:0] strap_r;
  reg [4:0] linkst_r;
  reg [`PLSC_CNT_W-1:0] div10_r;
  reg [`PLSC_CNT_W-1:0] div20_r;
  reg blink10_r;
  reg blink20_r;
  reg [4:0] led_nxt;
  wire pdown;
  wire in_reset;

  function [15:0] plsc_word;
    input [3:0] a;
    input [15:0] basic;
    input [15:0] coding;
    input [15:0] strap;
    input [4:0] ls;
    input [1:0] st;
    begin
      case (a)
        `PLSC_ADDR_BASIC: plsc_word = basic;
        `PLSC_ADDR_CODING: plsc_word = coding;
        `PLSC_ADDR_STRAP: plsc_word = strap;
        `PLSC_ADDR_STATUS: plsc_word = {14'h0000, st};
        `PLSC_ADDR_LINK: plsc_word = {11'h000, ls};
        default: plsc_word = 16'h0000;
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // Reset sequencing
  // --------------------------------------------------------------
  // Either reset source restarts the counter, so the counted hold covers power-up too.
  assign in_reset = (state_r == ST_RESET);

  always @(posedge clock)
  begin
    if (reset || !reset_n_pin)
    begin
      state_r <= ST_RESET;
      rst_cnt_r <= 32'h00000000;
    end
    else
    begin
      case (state_r)
        ST_RESET:
        begin
          if (rst_cnt_r >= RESET_CYCLES - 1)
            state_r <= ST_RUN;
          else
            rst_cnt_r <= rst_cnt_r + 32'h00000001;
        end
        ST_RUN: state_r <= ST_RUN;
        default: state_r <= ST_RESET;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Control registers, straps and configuration pins
  // --------------------------------------------------------------
  always @(posedge clock)
  begin
    if (reset || !reset_n_pin)
    begin
      basic_r <= `PLSC_RESET_BASIC;
      coding_r <= `PLSC_RESET_CODING;
      strap_r <= 16'h0000;
      linkst_r <= 5'h00;
      advert_mode <= 2'h0;
    end
    else if (in_reset)
    begin
      // Straps are caught on the last reset cycle, while the LED pins are still released.
      if (rst_cnt_r >= RESET_CYCLES - 1)
      begin
        strap_r[`PLSC_SS_SPEED10] <= led_in[4];
        strap_r[`PLSC_SS_ACT] <= led_in[3];
        strap_r[`PLSC_SS_LINK] <= led_in[2];
        strap_r[`PLSC_SS_DUPCOL] <= led_in[1];
        strap_r[`PLSC_SS_SPEED100] <= led_in[0];
        basic_r[`PLSC_BC_ANEG] <= autoneg_strap_pin;
        basic_r[`PLSC_BC_DUPLEX] <= full_duplex_pin;
        if (autoneg_strap_pin)
          advert_mode <= {config_input_one, config_input_zero};
        else
        begin
          coding_r[`PLSC_CC_MLT3_BYPASS] <= config_input_zero;
          basic_r[`PLSC_BC_LOOPBACK] <= config_input_one;
        end
      end
    end
    else if (wr)
    begin
      case (addr)
        `PLSC_ADDR_BASIC: basic_r <= wdata;
        `PLSC_ADDR_CODING: coding_r <= wdata;
        `PLSC_ADDR_LINK: linkst_r <= wdata[4:0];
        default: basic_r <= basic_r;
      endcase
    end
  end

  // Read data stand in the cycle after the strobe only.
  always @(posedge clock)
  begin
    if (reset)
      rdata <= 16'h0000;
    else if (rd)
      rdata <= plsc_word(addr, basic_r, coding_r, strap_r, linkst_r, {pdown, reset_done});
    else
      rdata <= 16'h0000;
  end

  // --------------------------------------------------------------
  // Blink dividers
  // --------------------------------------------------------------
  // Free running, so blink phase is unrelated to when activity starts.
  always @(posedge clock)
  begin
    if (reset)
    begin
      div10_r <= {`PLSC_CNT_W{1'b0}};
      div20_r <= {`PLSC_CNT_W{1'b0}};
      blink10_r <= 1'b0;
      blink20_r <= 1'b0;
    end
    else
    begin
      if (div10_r == `PLSC_HALF10_CYC - 1)
      begin
        div10_r <= {`PLSC_CNT_W{1'b0}};
        blink10_r <= ~blink10_r;
      end
      else
        div10_r <= div10_r + 1'b1;
      if (div20_r == `PLSC_HALF20_CYC - 1)
      begin
        div20_r <= {`PLSC_CNT_W{1'b0}};
        blink20_r <= ~blink20_r;
      end
      else
        div20_r <= div20_r + 1'b1;
    end
  end

  // --------------------------------------------------------------
  // LED patterns and power down
  // --------------------------------------------------------------
  assign pdown = power_down_pin | basic_r[`PLSC_BC_PDOWN];

  always @*
  begin
    led_nxt[4] = linkst_r[`PLSC_LS_SPEED10];
    led_nxt[0] = linkst_r[`PLSC_LS_SPEED100];
    led_nxt[3] = linkst_r[`PLSC_LS_ACT] & blink10_r;
    if (linkst_r[`PLSC_LS_ACT])
      led_nxt[2] = blink10_r;
    else
      led_nxt[2] = linkst_r[`PLSC_LS_LINK];
    if (basic_r[`PLSC_BC_DUPLEX])
      led_nxt[1] = 1'b1;
    else
      led_nxt[1] = linkst_r[`PLSC_LS_COL] & blink20_r;
  end

  always @(posedge clock)
  begin
    if (reset)
    begin
      led_out <= 5'h00;
      led_oe <= 5'h00;
      reset_done <= 1'b0;
      tx_line_oe <= 1'b0;
      mii_isolate <= 1'b1;
    end
    else
    begin
      reset_done <= ~in_reset;
      led_out <= led_nxt;
      led_oe <= (in_reset || pdown) ? 5'h00 : 5'h1F;
      tx_line_oe <= ~in_reset & ~pdown;
      mii_isolate <= in_reset | pdown;
    end
  end

endmodule // plsc_top

// *** sim/plsc_board.sv ***
// Board model: LED pins with their strap resistors.
`timescale 1ns/100ps
module plsc_board
(
  input wire [4:0] strap,
  input wire [4:0] led_out,
  input wire [4:0] led_oe,
  output wire [4:0] led_in
);
  // A released pin settles to its resistor level, never to the last driven value.
  assign led_in = (led_oe & led_out) | (~led_oe & strap);
endmodule // plsc_board

// *** sim/plsc_props.sv ***
// Concurrent checks on the ports of the LED, strap and reset control block.
`timescale 1ns/100ps
module plsc_props
#(
  parameter RESET_CYCLES = 20
)
(
  input wire clock,
  input wire reset,
  input wire reset_n_pin,
  input wire power_down_pin,
  input wire [3:0] addr,
  input wire rd,
  input wire [4:0] led_oe,
  input wire reset_done,
  input wire tx_line_oe,
  input wire mii_isolate,
  input wire [15:0] rdata
);
  integer cnt_r;
  // Counting from the last release of either reset shows whether completion came too soon.
  always @(posedge clock)
    if (reset || !reset_n_pin)
      cnt_r <= 0;
    else if (!reset_done)
      cnt_r <= cnt_r + 1;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_rip_span: assert property ($rose(reset_done) |-> cnt_r >= RESET_CYCLES)
    else $error("reset completed too early");
  a_rip_drop: assert property ($fell(reset_n_pin) |-> ##[1:3] !reset_done)
    else $error("reset pin did not clear completion");
  a_oe_reset: assert property (!reset_done |-> led_oe == 5'h00)
    else $error("LED driven during reset");
  a_tx_reset: assert property (!reset_done |-> !tx_line_oe && mii_isolate)
    else $error("line driven during reset");
  a_pd_pin: assert property (power_down_pin[*2] |=> led_oe == 5'h00 && !tx_line_oe && mii_isolate)
    else $error("power down pin ignored");
  a_led_on: assert property ($rose(reset_done) && !power_down_pin |-> ##[0:2] led_oe == 5'h1F)
    else $error("LED pins not driven after reset");
  a_unmapped_rd: assert property (rd && addr > 4'h4 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read cycle");
  c_done: cover property ($rose(reset_done));
  c_pdown: cover property (power_down_pin && reset_done);
  c_read: cover property (rd && addr == 4'h2);
endmodule // plsc_props
bind plsc_top plsc_props #(.RESET_CYCLES(RESET_CYCLES)) plsc_props_inst (.clock, .reset, .reset_n_pin,
  .power_down_pin, .addr, .rd, .led_oe, .reset_done, .tx_line_oe, .mii_isolate, .rdata);

// *** sim/plsc_top_tb.sv ***
// Self-checking bench for the LED, strap and reset control block.
`timescale 1ns/100ps
module plsc_top_tb;
  localparam RC = 20;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg reset_n_pin = 1'b1;
  reg power_down_pin = 1'b0;
  reg autoneg_strap_pin = 1'b0;
  reg config_input_zero = 1'b1;
  reg config_input_one = 1'b1;
  reg full_duplex_pin = 1'b1;
  reg [4:0] strap = 5'h16;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [4:0] led_in;
  wire [4:0] led_out;
  wire [4:0] led_oe;
  wire reset_done;
  wire tx_line_oe;
  wire mii_isolate;
  wire [1:0] advert_mode;
  wire [15:0] rdata;
  integer failures = 0;
  integer checks_done = 0;
  integer n;
  plsc_top #(.RESET_CYCLES(RC)) plsc_top_inst (.clock, .reset, .reset_n_pin, .power_down_pin, .autoneg_strap_pin,
    .config_input_zero, .config_input_one, .full_duplex_pin, .led_in, .led_out, .led_oe, .reset_done,
    .tx_line_oe, .mii_isolate, .advert_mode, .addr, .wdata, .wr, .rd, .rdata);
  plsc_board plsc_board_inst (.strap, .led_out, .led_oe, .led_in);
  initial
    forever #5 clock = ~clock;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input string what, input [15:0] seen, input [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr_reg(input [3:0] a, input [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task rd_reg(input string what, input [3:0] a, input [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(what, rdata, exp);
  endtask
  task wait_done;
    n = 0;
    while (reset_done !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      n = n + 1;
    end
    #1 check("reset span", 16'(n >= RC && n <= RC + 8), 16'h0001);
  endtask
  task conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_power_up;
    wait_done;
    rd_reg("strap", 4'h2, 16'h00B0);
    rd_reg("coding", 4'h1, 16'h0002);
    rd_reg("basic", 4'h0, 16'h4100);
    rd_reg("unmapped", 4'hF, 16'h0000);
  endtask
  task t_leds;
    wr_reg(4'h4, 16'h0001);
    check("led 10", 16'(led_out), 16'h0012);
    wr_reg(4'h4, 16'h0006);
    check("led 100", 16'(led_out), 16'h0007);
    wr_reg(4'h4, 16'h000C);
    check("led act", 16'(led_out), 16'h0002);
  endtask
  task t_power_down;
    @(posedge clock);
    power_down_pin <= 1'b1;
    repeat (3) @(posedge clock);
    #1 check("pd pin", 16'({led_oe, tx_line_oe, mii_isolate}), 16'h0001);
    @(posedge clock);
    power_down_pin <= 1'b0;
    wr_reg(4'h0, 16'h4900);
    check("pd bit", 16'({led_oe, tx_line_oe, mii_isolate}), 16'h0001);
    rd_reg("status", 4'h3, 16'h0003);
    wr_reg(4'h0, 16'h4100);
    check("pd off", 16'({led_oe, tx_line_oe, mii_isolate}), 16'h007E);
  endtask
  task t_autoneg;
    @(posedge clock);
    reset_n_pin <= 1'b0;
    autoneg_strap_pin <= 1'b1;
    config_input_zero <= 1'b0;
    strap <= 5'h09;
    repeat (RC + 2) @(posedge clock);
    #1 check("rip low", 16'({reset_done, led_oe}), 16'h0000);
    @(posedge clock);
    reset_n_pin <= 1'b1;
    wait_done;
    check("advert", 16'(advert_mode), 16'h0002);
    rd_reg("restrap", 4'h2, 16'h0048);
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    t_power_up;
    t_leds;
    t_power_down;
    t_autoneg;
    conclude;
  end
  initial
  begin
    #20000;
    failures = failures + 1;
    conclude;
  end
endmodule // plsc_top_tb
